// ---- shared/irq_ctrl_pkg.sv ----
// Constants for the two-level interrupt controller
package irq_ctrl_pkg;

  localparam int NUM_SRC = 11;

  // Source index is the polling rank, 0 polled first
  localparam int SRC_PSM = 0;
  localparam int SRC_WDT = 1;
  localparam int SRC_EXT0 = 2;
  localparam int SRC_ADC = 3;
  localparam int SRC_T0 = 4;
  localparam int SRC_EXT1 = 5;
  localparam int SRC_T1 = 6;
  localparam int SRC_SER = 7;
  localparam int SRC_UART = 8;
  localparam int SRC_T2 = 9;
  localparam int SRC_TIC = 10;

  localparam logic [7:0] ADDR_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_PRIORITY = 8'hb8;
  localparam logic [7:0] ADDR_SECONDARY = 8'ha9;

  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_PRIORITY = 8'h00;
  localparam logic [7:0] RESET_SECONDARY = 8'ha0;

  // Enable / priority register fields
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_ADC = 6;
  localparam int BIT_T2 = 5;
  localparam int BIT_UART = 4;
  localparam int BIT_T1 = 3;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_T0 = 1;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_PRI_RSVD = 7;

  // Secondary register fields
  localparam int BIT_TIC_PRI = 6;
  localparam int BIT_PSM_PRI = 5;
  localparam int BIT_SER_PRI = 4;
  localparam int BIT_TIC_EN = 2;
  localparam int BIT_PSM_EN = 1;
  localparam int BIT_SER_EN = 0;

  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_T0 = 16'h000b;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_T1 = 16'h001b;
  localparam logic [15:0] VEC_UART = 16'h0023;
  localparam logic [15:0] VEC_T2 = 16'h002b;
  localparam logic [15:0] VEC_ADC = 16'h0033;
  localparam logic [15:0] VEC_SER = 16'h003b;
  localparam logic [15:0] VEC_PSM = 16'h0043;
  localparam logic [15:0] VEC_TIC = 16'h0053;
  localparam logic [15:0] VEC_WDT = 16'h005b;

endpackage

// ---- core/irq_ctrl.sv ----
// Two-level interrupt controller with SFR register port
`timescale 1ns/1ns
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  // SFR byte access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // SFR bit access
  input wire logic bit_wr,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wdata,
  // Source requests, levels from on-chip logic
  input wire logic supply_monitor_irq,
  input wire logic watchdog_irq,
  input wire logic ext_irq0_request,
  input wire logic adc_done_irq,
  input wire logic timer0_overflow,
  input wire logic ext_irq1_request,
  input wire logic timer1_overflow,
  input wire logic serial_sync_irq,
  input wire logic uart_rx_tx_irq,
  input wire logic timer2_irq,
  input wire logic interval_timer_irq,
  // Core side
  output logic irq_req,
  output logic [15:0] irq_vector,
  output logic [3:0] irq_source,
  output logic irq_level_high,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic active_high,
  output logic active_low
);

  logic [7:0] enable_reg;
  logic [7:0] priority_reg;
  logic [7:0] secondary_reg;
  logic [7:0] enable_next;
  logic [7:0] priority_next;
  logic [7:0] secondary_next;
  logic [7:0] rdata_next;
  logic active_high_reg;
  logic active_low_reg;
  logic act_high_next;
  logic act_low_next;
  logic irq_req_reg;
  logic [15:0] vector_reg;
  logic [3:0] source_reg;
  logic level_reg;
  logic req_next;
  logic level_next;
  logic [3:0] source_next;

  // Byte decode, bit decode on the bit-addressable rows
  wire wr_enable = sfr_wr && (sfr_addr == ADDR_ENABLE);
  wire wr_priority = sfr_wr && (sfr_addr == ADDR_PRIORITY);
  wire wr_secondary = sfr_wr && (sfr_addr == ADDR_SECONDARY);
  wire bit_enable = bit_wr && (bit_addr[7:3] == ADDR_ENABLE[7:3]);
  wire bit_priority = bit_wr && (bit_addr[7:3] == ADDR_PRIORITY[7:3]);
  wire [2:0] bit_sel = bit_addr[2:0];

  // Bit writes touch one bit only
  function automatic logic [7:0] set_bit(input logic [7:0] v,
    input logic [2:0] idx, input logic b);
    logic [7:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction

  assign enable_next = wr_enable ? sfr_wdata :
    bit_enable ? set_bit(enable_reg, bit_sel, bit_wdata) : enable_reg;
  assign priority_next = wr_priority ? sfr_wdata :
    bit_priority ? set_bit(priority_reg, bit_sel, bit_wdata) :
    priority_reg;
  // Bit 3 stored as written; software keeps it clear
  assign secondary_next = wr_secondary ? sfr_wdata : secondary_reg;

  wire [7:0] priority_view = {1'b0, priority_reg[6:0]};
  assign rdata_next = (sfr_addr == ADDR_ENABLE) ? enable_reg :
    (sfr_addr == ADDR_PRIORITY) ? priority_view :
    (sfr_addr == ADDR_SECONDARY) ? secondary_reg : 8'h00;

  // Request vector in polling rank order
  wire [NUM_SRC-1:0] src_req;
  assign src_req[SRC_PSM] = supply_monitor_irq;
  assign src_req[SRC_WDT] = watchdog_irq;
  assign src_req[SRC_EXT0] = ext_irq0_request;
  assign src_req[SRC_ADC] = adc_done_irq;
  assign src_req[SRC_T0] = timer0_overflow;
  assign src_req[SRC_EXT1] = ext_irq1_request;
  assign src_req[SRC_T1] = timer1_overflow;
  assign src_req[SRC_SER] = serial_sync_irq;
  assign src_req[SRC_UART] = uart_rx_tx_irq;
  assign src_req[SRC_T2] = timer2_irq;
  assign src_req[SRC_TIC] = interval_timer_irq;

  // Per-source enables; watchdog has no enable bit
  wire [NUM_SRC-1:0] src_en;
  assign src_en[SRC_PSM] = secondary_reg[BIT_PSM_EN];
  assign src_en[SRC_WDT] = 1'b1;
  assign src_en[SRC_EXT0] = enable_reg[BIT_EXT0];
  assign src_en[SRC_ADC] = enable_reg[BIT_ADC];
  assign src_en[SRC_T0] = enable_reg[BIT_T0];
  assign src_en[SRC_EXT1] = enable_reg[BIT_EXT1];
  assign src_en[SRC_T1] = enable_reg[BIT_T1];
  assign src_en[SRC_SER] = secondary_reg[BIT_SER_EN];
  assign src_en[SRC_UART] = enable_reg[BIT_UART];
  assign src_en[SRC_T2] = enable_reg[BIT_T2];
  assign src_en[SRC_TIC] = secondary_reg[BIT_TIC_EN];

  // Per-source level; watchdog has no priority bit and stays low
  wire [NUM_SRC-1:0] src_pri;
  assign src_pri[SRC_PSM] = secondary_reg[BIT_PSM_PRI];
  assign src_pri[SRC_WDT] = 1'b0;
  assign src_pri[SRC_EXT0] = priority_reg[BIT_EXT0];
  assign src_pri[SRC_ADC] = priority_reg[BIT_ADC];
  assign src_pri[SRC_T0] = priority_reg[BIT_T0];
  assign src_pri[SRC_EXT1] = priority_reg[BIT_EXT1];
  assign src_pri[SRC_T1] = priority_reg[BIT_T1];
  assign src_pri[SRC_SER] = secondary_reg[BIT_SER_PRI];
  assign src_pri[SRC_UART] = priority_reg[BIT_UART];
  assign src_pri[SRC_T2] = priority_reg[BIT_T2];
  assign src_pri[SRC_TIC] = secondary_reg[BIT_TIC_PRI];

  wire [NUM_SRC-1:0] eligible =
    src_req & src_en & {NUM_SRC{enable_reg[BIT_GLOBAL]}};
  wire [NUM_SRC-1:0] cand_high = eligible & src_pri;
  wire [NUM_SRC-1:0] cand_low = eligible & ~src_pri;

  // Level bookkeeping; the next state feeds arbitration so an
  // accepted request does not show up again one cycle late
  always_comb begin
    act_high_next = active_high_reg;
    act_low_next = active_low_reg;
    if (irq_return) begin
      if (active_high_reg) begin
        act_high_next = 1'b0;
      end else begin
        act_low_next = 1'b0;
      end
    end
    if (irq_ack && irq_req_reg) begin
      if (level_reg) begin
        act_high_next = 1'b1;
      end else begin
        act_low_next = 1'b1;
      end
    end
  end

  // Rank chain per level: a source wins when no earlier rank asks;
  // the chain carries the winner's code, so no encoder loop is needed
  wire [NUM_SRC:0] high_seen;
  wire [NUM_SRC:0] low_seen;
  wire [3:0] high_code [NUM_SRC+1];
  wire [3:0] low_code [NUM_SRC+1];
  assign high_seen[0] = 1'b0;
  assign low_seen[0] = 1'b0;
  assign high_code[0] = 4'h0;
  assign low_code[0] = 4'h0;
  for (genvar g = 0; g < NUM_SRC; g = g + 1) begin : g_rank
    wire high_win = cand_high[g] && !high_seen[g];
    wire low_win = cand_low[g] && !low_seen[g];
    assign high_seen[g+1] = high_seen[g] || cand_high[g];
    assign low_seen[g+1] = low_seen[g] || cand_low[g];
    assign high_code[g+1] = high_win ? 4'(g) : high_code[g];
    assign low_code[g+1] = low_win ? 4'(g) : low_code[g];
  end
  wire [3:0] high_pick = high_code[NUM_SRC];
  wire [3:0] low_pick = low_code[NUM_SRC];

  wire high_ok = !act_high_next && (|cand_high);
  wire low_ok = !act_high_next && !act_low_next && (|cand_low);

  always_comb begin
    req_next = 1'b0;
    level_next = 1'b0;
    source_next = 4'h0;
    if (high_ok) begin
      req_next = 1'b1;
      level_next = 1'b1;
      source_next = high_pick;
    end else if (low_ok) begin
      req_next = 1'b1;
      source_next = low_pick;
    end
  end

  function automatic logic [15:0] vector_of(input logic [3:0] s);
    logic [15:0] r;
    r = VEC_EXT0;
    case (s)
      4'(SRC_PSM): r = VEC_PSM;
      4'(SRC_WDT): r = VEC_WDT;
      4'(SRC_EXT0): r = VEC_EXT0;
      4'(SRC_ADC): r = VEC_ADC;
      4'(SRC_T0): r = VEC_T0;
      4'(SRC_EXT1): r = VEC_EXT1;
      4'(SRC_T1): r = VEC_T1;
      4'(SRC_SER): r = VEC_SER;
      4'(SRC_UART): r = VEC_UART;
      4'(SRC_T2): r = VEC_T2;
      4'(SRC_TIC): r = VEC_TIC;
      default: r = VEC_EXT0;
    endcase
    return r;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enable_reg <= RESET_ENABLE;
      priority_reg <= RESET_PRIORITY;
      secondary_reg <= RESET_SECONDARY;
      sfr_rdata <= 8'h00;
    end else begin
      enable_reg <= enable_next;
      priority_reg <= priority_next;
      secondary_reg <= secondary_next;
      sfr_rdata <= sfr_rd ? rdata_next : sfr_rdata;
    end
  end

  // Core pushes PC on irq_ack and jumps to irq_vector
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      active_high_reg <= 1'b0;
      active_low_reg <= 1'b0;
      irq_req_reg <= 1'b0;
      vector_reg <= 16'h0000;
      source_reg <= 4'h0;
      level_reg <= 1'b0;
    end else begin
      active_high_reg <= act_high_next;
      active_low_reg <= act_low_next;
      irq_req_reg <= req_next;
      vector_reg <= vector_of(source_next);
      source_reg <= source_next;
      level_reg <= level_next;
    end
  end

  assign irq_req = irq_req_reg;
  assign irq_vector = vector_reg;
  assign irq_source = source_reg;
  assign irq_level_high = level_reg;
  assign active_high = active_high_reg;
  assign active_low = active_low_reg;

endmodule

// ---- test/irq_ctrl_asserts.sv ----
// Port assertions for the interrupt controller
`timescale 1ns/1ns
module irq_ctrl_asserts
  import irq_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0] irq_source,
  input wire logic irq_level_high,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic active_high,
  input wire logic active_low
);
  localparam logic [15:0] VT [11] = '{VEC_PSM, VEC_WDT, VEC_EXT0,
    VEC_ADC, VEC_T0, VEC_EXT1, VEC_T1, VEC_SER, VEC_UART, VEC_T2, VEC_TIC};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_vector_table: assert property (irq_req |->
    irq_vector == VT[irq_source]) else $error("Vector mismatch");
  a_ack_enters: assert property (irq_req && irq_ack |=>
    ($past(irq_level_high) ? active_high : active_low))
    else $error("Accept did not mark level active");
  a_high_blocks: assert property (active_high |-> !irq_req)
    else $error("Request offered while high routine active");
  a_low_preempt: assert property (active_low |->
    !irq_req || irq_level_high) else $error("Low request nested");
  a_ack_drops: assert property (irq_req && irq_ack |=>
    !irq_req || (irq_level_high && !$past(irq_level_high)))
    else $error("Request stayed after accept");
  a_return_high: assert property (irq_return && active_high |=>
    !active_high) else $error("High flag not cleared");
  a_return_low: assert property (
    irq_return && !active_high && !irq_ack |=> !active_low)
    else $error("Low flag not cleared");
  a_gate_reset: assert property ($fell(reset) |->
    !irq_req && !active_high && !active_low)
    else $error("Request or activity right after reset");
  cover property (active_high && active_low);
  cover property (irq_req && irq_ack && irq_level_high);
  cover property (irq_return && active_low);
  cover property (irq_req && irq_level_high && irq_source == 4'(SRC_TIC));
endmodule

bind irq_ctrl irq_ctrl_asserts i_chk (.sys_clk(sys_clk), .reset(reset),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source),
  .irq_level_high(irq_level_high), .irq_ack(irq_ack),
  .irq_return(irq_return), .active_high(active_high),
  .active_low(active_low));

// ---- test/core_model.sv ----
// Core-side model: accepts offered vectors, nests program counters
`timescale 1ns/1ns
module core_model (
  input wire logic sys_clk,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic take,
  input wire logic irq_return,
  output logic irq_ack,
  output logic [15:0] pc
);
  logic [15:0] stack [$];
  // Ack only while offered, so each accept is one pulse
  assign irq_ack = irq_req && take;
  initial pc = 16'h0100;
  always @(posedge sys_clk) begin
    if (irq_ack) begin
      stack.push_back(pc);
      pc <= irq_vector;
    end else if (irq_return && stack.size() > 0) begin
      pc <= stack.pop_back();
    end
  end
endmodule

// ---- test/test_irq_ctrl.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
module test_irq_ctrl
  import irq_ctrl_pkg::*;
;
  logic sys_clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, bit_wr = 0;
  logic bit_wdata = 0, take = 0, irq_return = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic [7:0] sfr_rdata;
  logic [10:0] src = 11'h000;
  logic irq_req, irq_ack, irq_level_high, active_high, active_low;
  logic [15:0] irq_vector, pc;
  logic [3:0] irq_source;
  int n_mismatch = 0, checks_done = 0;
  localparam logic [15:0] VT [11] = '{VEC_PSM, VEC_WDT, VEC_EXT0,
    VEC_ADC, VEC_T0, VEC_EXT1, VEC_T1, VEC_SER, VEC_UART, VEC_T2, VEC_TIC};
  always #10 sys_clk = ~sys_clk;
  irq_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .bit_wr(bit_wr), .bit_addr(bit_addr),
    .bit_wdata(bit_wdata), .supply_monitor_irq(src[SRC_PSM]),
    .watchdog_irq(src[SRC_WDT]), .ext_irq0_request(src[SRC_EXT0]),
    .adc_done_irq(src[SRC_ADC]), .timer0_overflow(src[SRC_T0]),
    .ext_irq1_request(src[SRC_EXT1]), .timer1_overflow(src[SRC_T1]),
    .serial_sync_irq(src[SRC_SER]), .uart_rx_tx_irq(src[SRC_UART]),
    .timer2_irq(src[SRC_T2]), .interval_timer_irq(src[SRC_TIC]),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source),
    .irq_level_high(irq_level_high), .irq_ack(irq_ack),
    .irq_return(irq_return), .active_high(active_high),
    .active_low(active_low));
  core_model i_core (.sys_clk(sys_clk), .irq_req(irq_req),
    .irq_vector(irq_vector), .take(take), .irq_return(irq_return),
    .irq_ack(irq_ack), .pc(pc));

  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  // Every drive lands 1 ns after the edge; strobes rest one cycle
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    step();
    sfr_wr = 0;
    step();
  endtask
  task automatic bwr(logic [7:0] a, logic b);
    bit_addr = a;
    bit_wdata = b;
    bit_wr = 1;
    step();
    bit_wr = 0;
    step();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string what);
    sfr_addr = a;
    sfr_rd = 1;
    step();
    sfr_rd = 0;
    step();
    chk(what, {8'h00, e}, {8'h00, sfr_rdata});
  endtask
  task automatic get(int i, logic lvl = 1'b0);
    for (int k = 0; k < 8 && irq_req !== 1'b1; k++) step();
    chk("request", 16'h0001, {15'h0000, irq_req});
    chk("source", 16'(i), {12'h000, irq_source});
    chk("level", {15'h0000, lvl}, {15'h0000, irq_level_high});
    chk("vector", VT[i], irq_vector);
    take = 1;
    step();
    take = 0;
    src[i] = 0;
    chk("pc", VT[i], pc);
  endtask
  task automatic ret();
    irq_return = 1;
    step();
    irq_return = 0;
    step();
  endtask
  task automatic none();
    repeat (3) step();
    chk("idle request", 16'h0000, {15'h0000, irq_req});
  endtask

  initial begin
    repeat (6) step();
    reset = 0;
    rd(ADDR_ENABLE, 8'h00, "enable");
    rd(ADDR_PRIORITY, 8'h00, "priority");
    rd(ADDR_SECONDARY, 8'ha0, "secondary");
    rd(8'h00, 8'h00, "unmapped");
    wr(ADDR_PRIORITY, 8'hff);
    rd(ADDR_PRIORITY, 8'h7f, "priority");
    bwr(8'hb8, 1'b0);
    rd(ADDR_PRIORITY, 8'h7e, "priority bit");
    wr(ADDR_PRIORITY, 8'h00);
    // Bit address A9 is an enable bit, never the secondary register
    bwr(8'ha9, 1'b1);
    rd(ADDR_SECONDARY, 8'ha0, "secondary");
    rd(ADDR_ENABLE, 8'h02, "enable bit");
    src[SRC_T0] = 1;
    none();
    bwr(8'haf, 1'b1);
    get(SRC_T0);
    ret();
    wr(ADDR_ENABLE, 8'hff);
    wr(ADDR_SECONDARY, 8'h07);
    src = 11'h7ff;
    for (int i = 0; i < NUM_SRC; i++) begin
      get(i);
      ret();
    end
    wr(ADDR_ENABLE, 8'h80);
    wr(ADDR_SECONDARY, 8'h00);
    src = 11'h7ff;
    get(SRC_WDT);
    ret();
    none();
    src = 11'h000;
    wr(ADDR_ENABLE, 8'hff);
    wr(ADDR_PRIORITY, 8'h08);
    src[SRC_T0] = 1;
    src[SRC_T1] = 1;
    get(SRC_T1, 1'b1);
    none();
    ret();
    get(SRC_T0);
    src[SRC_T1] = 1;
    src[SRC_EXT1] = 1;
    get(SRC_T1, 1'b1);
    chk("nesting", 16'h0003, {14'h0000, active_high, active_low});
    ret();
    chk("return pc", VT[SRC_T0], pc);
    none();
    ret();
    get(SRC_EXT1);
    ret();
    // Secondary priority bit lifts the last-ranked source above timer 0
    wr(ADDR_SECONDARY, 8'h44);
    src[SRC_T0] = 1;
    src[SRC_TIC] = 1;
    get(SRC_TIC, 1'b1);
    ret();
    get(SRC_T0);
    ret();
    give_verdict();
  end
  // About 120 cycles expected; cut off well beyond
  initial begin
    #60000;
    n_mismatch++;
    give_verdict();
  end
endmodule
